// [design/sadc_regs.svh]
// register offsets, field positions, reset values and timing counts for the converter control
// Contract
// - a started conversion always completes; new strobes and power-down cannot abort it
// - convert strobe works regardless of select and read strobes
// - strobe held low while idle repeats acquisition and conversion automatically
// - outputs float unless select and read are both low
// - coding select picks binary or twos complement except in 18-bit mode
// - serial port shares pins with the parallel data bus; here serial_data_out and ser are separate ports
// - parallel bus width is 18, 16 or 8 bits by mode inputs
// - result stays readable through next acquisition and next conversion
// - both mode inputs high select the serial interface
// - serial result goes out msb first over 18 clock pulses
// - each serial bit is stable across both clock edges
// - clock-source select low makes the device serial clock master
// - master mode drives a data-valid strobe
// - serial clock and data-valid polarity are invertible
// - read-timing input picks send after conversion or during next
// - master read-after-conversion keeps busy high until 18 bits are out
// - divider inputs slow the generated serial clock
// - power is cut automatically at the end of each conversion
// - interface stays operational during low-power acquisition
// - after bit decisions the code is formed and busy drops
// - binary midscale 20000 hex; twos complement midscale 00000
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_APB_CTRL 12'h000
`define SADC_APB_STAT 12'h004
`define SADC_APB_SAMPLE 12'h008
`define SADC_APB_RESULT 12'h00c
`define SADC_CTRL_INV_BIT 0
`define SADC_CTRL_RST 32'h0000_0000
`define SADC_CLK_MHZ 100
`define SADC_CONV_NS 1500
`define SADC_CONV_CYC ((`SADC_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_ACQ_NS 250
`define SADC_ACQ_CYC ((`SADC_ACQ_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_NBITS 18
`define SADC_MID 18'h20000
`endif

// [design/sadc_pkg.sv]
// types shared by the converter control
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01,
        SADC_ACQ = 2'b10,
        SADC_SEND = 2'b11
    } sadc_state_t;
    typedef struct packed {
        logic [17:0] data;
        logic [17:0] data_oe_n;
    } sadc_bus_t;
    typedef struct packed {
        logic sclk;
        logic sclk_oe_n;
        logic sync;
    } sadc_ser_t;
endpackage

// [design/sadc_core.sv]
// conversion control, parallel/serial result port and apb register slave
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module sadc_core
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter pins
    input wire logic convert_start_n,
    input wire logic power_down,
    input wire logic chip_sel_n,
    input wire logic read_n,
    input wire logic output_coding_sel,
    input wire logic interface_sel0,
    input wire logic interface_sel1,
    input wire logic clock_source_sel,
    input wire logic read_timing_or_chain_in,
    input wire logic [1:0] serial_clock_divider,
    input wire logic refbuf_powerdown,
    output logic busy,
    output sadc_bus_t data_bus,
    output sadc_ser_t ser,
    output logic serial_data_out,
    output logic core_power_on,
    output logic refbuf_enable
);
    sadc_state_t state_r;
    logic [17:0] sample_r;
    logic [17:0] result_r;
    logic [17:0] sar_r;
    logic [7:0] cnt_r;
    logic cnv_d_r;
    logic [31:0] ctrl_r;
    logic [4:0] bit_r;
    logic [7:0] div_r;
    logic sending_r;
    logic sclk_int_r;
    logic ser_pend_r;
    logic [17:0] shift_r;
    logic [17:0] code;
    logic [17:0] par_word;
    logic serial_mode;
    logic master_mode;
    logic rac_mode;
    logic start;
    logic div_tick;
    logic [7:0] div_max;
    logic apb_acc;
    logic conv_go;
    logic [9:0] busy_len_r;

    assign serial_mode = interface_sel0 && interface_sel1;
    assign master_mode = serial_mode && !clock_source_sel;
    assign rac_mode = master_mode && !read_timing_or_chain_in;
    // falling strobe or strobe held low while idle starts a conversion
    assign start = !convert_start_n && (cnv_d_r || state_r == SADC_IDLE);
    // a conversion begins from idle, on a falling strobe during acquisition,
    // or when the strobe is still low as the acquisition count runs out
    assign conv_go = !power_down
        && ((state_r == SADC_IDLE && start)
        || (state_r == SADC_ACQ && (start || (cnt_r == 8'h00 && !convert_start_n))));

    // two's complement flips msb except in 18-bit parallel mode
    always_comb begin
        if (!output_coding_sel && (serial_mode || interface_sel0 || interface_sel1)) begin
            code = sar_r ^ `SADC_MID;
        end else begin
            code = sar_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnv_d_r <= 1'b1;
        end else begin
            cnv_d_r <= convert_start_n;
        end
    end

    // conversion sequencer; power_down is ignored mid conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SADC_IDLE;
            cnt_r <= 8'h00;
            result_r <= 18'h00000;
            ser_pend_r <= 1'b0;
        end else begin
            ser_pend_r <= 1'b0;
            case (state_r)
                SADC_IDLE: begin
                    if (conv_go) begin
                        state_r <= SADC_CONV;
                        cnt_r <= 8'(`SADC_CONV_CYC - 1);
                    end
                end
                SADC_CONV: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        result_r <= code;
                        // only read-after mode sends the fresh result; read-during
                        // mode already sent the previous one at conversion start
                        ser_pend_r <= rac_mode;
                        state_r <= rac_mode ? SADC_SEND : SADC_ACQ;
                        cnt_r <= 8'(`SADC_ACQ_CYC - 1);
                    end
                end
                SADC_SEND: begin
                    if (!sending_r && !ser_pend_r) begin
                        state_r <= SADC_ACQ;
                    end
                end
                SADC_ACQ: begin
                    if (conv_go) begin
                        state_r <= SADC_CONV;
                        cnt_r <= 8'(`SADC_CONV_CYC - 1);
                    end else if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        state_r <= SADC_IDLE;
                    end
                end
                default: state_r <= SADC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_r <= 18'h00000;
        end else if (conv_go) begin
            // input is captured at the edge that starts the conversion
            sar_r <= sample_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            core_power_on <= 1'b0;
        end else begin
            busy <= (state_r == SADC_CONV) || (state_r == SADC_SEND);
            core_power_on <= (state_r == SADC_CONV);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refbuf_enable <= 1'b0;
        end else begin
            refbuf_enable <= !refbuf_powerdown;
        end
    end

    // parallel word: 18 bits, 16 msbs, or 8-bit byte selected by read timing pin
    always_comb begin
        if (!interface_sel1 && !interface_sel0) begin
            par_word = result_r;
        end else if (!interface_sel1) begin
            par_word = {2'b00, result_r[17:2]};
        end else if (read_timing_or_chain_in) begin
            par_word = {10'h000, result_r[17:10]};
        end else begin
            par_word = {10'h000, result_r[9:2]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_bus <= '{data: 18'h00000, data_oe_n: 18'h3ffff};
        end else if (chip_sel_n || read_n) begin
            data_bus.data_oe_n <= 18'h3ffff;
        end else if (serial_mode) begin
            data_bus.data_oe_n <= 18'h3ffff;
        end else begin
            data_bus.data <= par_word;
            data_bus.data_oe_n <= 18'h00000;
        end
    end

    // master serial clock divider
    always_comb begin
        case (serial_clock_divider)
            2'b00: div_max = 8'h00;
            2'b01: div_max = 8'h01;
            2'b10: div_max = 8'h03;
            default: div_max = 8'h07;
        endcase
    end
    assign div_tick = (div_r == div_max);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
        end else if (!sending_r || div_tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // serial shifter: data changes on sclk falling, so stable on both edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sending_r <= 1'b0;
            sclk_int_r <= 1'b0;
            bit_r <= 5'h00;
            shift_r <= 18'h00000;
        end else if (!sending_r) begin
            sclk_int_r <= 1'b0;
            if (master_mode && (ser_pend_r || (conv_go && read_timing_or_chain_in))) begin
                sending_r <= 1'b1;
                shift_r <= result_r;
                bit_r <= 5'(`SADC_NBITS);
            end
        end else if (div_tick) begin
            if (sclk_int_r) begin
                sclk_int_r <= 1'b0;
                shift_r <= {shift_r[16:0], 1'b0};
                if (bit_r == 5'h01) begin
                    sending_r <= 1'b0;
                end
                bit_r <= bit_r - 5'h01;
            end else begin
                sclk_int_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser <= '{sclk: 1'b0, sclk_oe_n: 1'b1, sync: 1'b0};
            serial_data_out <= 1'b0;
        end else begin
            ser.sclk <= sclk_int_r ^ ctrl_r[`SADC_CTRL_INV_BIT];
            ser.sync <= sending_r ^ ctrl_r[`SADC_CTRL_INV_BIT];
            ser.sclk_oe_n <= !master_mode;
            serial_data_out <= shift_r[17];
        end
    end

    // apb slave, zero wait states
    assign apb_acc = psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SADC_CTRL_RST;
            sample_r <= `SADC_MID;
        end else if (apb_acc && pwrite) begin
            if (paddr == `SADC_APB_CTRL) begin
                ctrl_r <= {31'h0, pwdata[0]};
            end else if (paddr == `SADC_APB_SAMPLE) begin
                sample_r <= pwdata[17:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                if (paddr == `SADC_APB_CTRL) begin
                    prdata <= ctrl_r;
                end else if (paddr == `SADC_APB_STAT) begin
                    prdata <= {27'h0, sending_r, busy, 1'b0, state_r};
                end else if (paddr == `SADC_APB_SAMPLE) begin
                    prdata <= {14'h0, sample_r};
                end else if (paddr == `SADC_APB_RESULT) begin
                    prdata <= {14'h0, result_r};
                end else begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // busy width tracker for the conversion length check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_len_r <= 10'h000;
        end else if (busy) begin
            busy_len_r <= busy_len_r + 10'h001;
        end else begin
            busy_len_r <= 10'h000;
        end
    end

    // checks
    busy_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_r == SADC_CONV) |=> busy) else $error("busy not raised");
    conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == SADC_CONV && cnt_r != 8'h00) |=> state_r == SADC_CONV)
        else $error("conversion aborted");
    hiz_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chip_sel_n || read_n) |=> &data_bus.data_oe_n) else $error("bus driven");
    ser_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        serial_mode |=> &data_bus.data_oe_n) else $error("serial bus driven");
    rac_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rac_mode && $fell(busy)) |-> (!sending_r && !ser_pend_r))
        else $error("busy early");
    bits_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sending_r) |-> bit_r == 5'd18) else $error("bit count");
    power_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == SADC_ACQ) |=> !core_power_on) else $error("power kept");
    refbuf_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
        refbuf_powerdown |=> !refbuf_enable) else $error("refbuf on");
    auto_run_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == SADC_ACQ ##1 state_r == SADC_CONV);
    rac_send_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == SADC_SEND ##1 state_r == SADC_ACQ);
    par_read_c: cover property (@(posedge pclk) disable iff (!presetn)
        !data_bus.data_oe_n[0] && busy);
    busy_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(busy) && !rac_mode) |-> busy_len_r == 10'(`SADC_CONV_CYC))
        else $error("busy width wrong");
    drive_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!chip_sel_n && !read_n && !serial_mode) |=> data_bus.data_oe_n == 18'h00000)
        else $error("bus not driven");
    shift_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sending_r && !(div_tick && sclk_int_r)) |=> $stable(shift_r))
        else $error("serial bit moved");
    sclk_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sending_r && !div_tick) |=> $stable(sclk_int_r))
        else $error("sclk toggled early");
    serial_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (interface_sel0 && interface_sel1 && !clock_source_sel) |=> !ser.sclk_oe_n)
        else $error("sclk not sourced");
    ser_frame_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(sending_r));
    byte_read_c: cover property (@(posedge pclk) disable iff (!presetn)
        interface_sel1 && !interface_sel0 && !data_bus.data_oe_n[0]);
endmodule
`default_nettype wire

// [sim/sadc_host_rx.sv]
// host-side serial receiver collecting one result word per frame
`timescale 1ns/1ps
`default_nettype none
module sadc_host_rx (
    // serial lines from the converter
    input wire logic sclk,
    input wire logic sync,
    input wire logic sdo,
    // collected word
    output logic [17:0] word,
    output logic [5:0] bits
);
    initial begin
        word = '0;
        bits = '0;
    end
    always @(posedge sync) begin
        bits = '0;
    end
    // sampled on the rising edge, the bit is held across both edges
    always @(posedge sclk) begin
        if (sync) begin
            word = {word[16:0], sdo};
            bits = bits + 6'h01;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module testbench;
    import sadc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, sdo, pwr, ref_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    logic cnv_n, pdn, cs_n, rd_n, coding, sel0, sel1, clk_src, rtc, refpd, err, bq;
    logic [1:0] div;
    logic [17:0] word, s, expv;
    // expected result of every conversion, oldest first
    logic [17:0] res_q[$];
    logic [5:0] bits;
    sadc_bus_t data_bus;
    sadc_ser_t ser;
    int miscompares = 0, compares = 0, w, n, i;
    sadc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convert_start_n(cnv_n), .power_down(pdn), .chip_sel_n(cs_n),
        .read_n(rd_n), .output_coding_sel(coding), .interface_sel0(sel0),
        .interface_sel1(sel1), .clock_source_sel(clk_src), .read_timing_or_chain_in(rtc),
        .serial_clock_divider(div), .refbuf_powerdown(refpd), .busy(busy),
        .data_bus(data_bus), .ser(ser), .serial_data_out(sdo), .core_power_on(pwr),
        .refbuf_enable(ref_en));
    sadc_host_rx u_host (.sclk(ser.sclk), .sync(ser.sync), .sdo(sdo), .word(word),
        .bits(bits));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            print_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits until busy (sel 0) or sync (sel 1) reaches v, returns cycles spent
    task automatic wait_for(input int sel, input logic v, output int c);
        c = 0;
        while ((sel ? ser.sync : busy) !== v && c < 2000) begin
            @(posedge pclk);
            c++;
        end
        if (c >= 2000) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic convert();
        @(posedge pclk);
        cnv_n <= 1'b0;
        @(posedge pclk);
        cnv_n <= 1'b1;
        wait_for(0, 1'b1, n);
        repeat (20) @(posedge pclk);
        cnv_n <= 1'b0;
        pdn <= 1'b1;
        @(posedge pclk);
        cnv_n <= 1'b1;
        pdn <= 1'b0;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pdn, sel0, sel1, rtc, refpd} = '0;
        {cnv_n, cs_n, rd_n, coding, clk_src} = '1;
        div = 2'b00;
        seed = 32'd79498;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(data_bus.data_oe_n, 32'h3ffff);
        chk(busy, 1'b0);
        chk(ref_en, 1'b1);
        apb(1'b0, `SADC_APB_SAMPLE, 32'h0);
        chk(q, 32'h20000);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        for (i = 0; i < 3; i++) begin
            seed = lfsr(lfsr(seed));
            s = seed[17:0];
            res_q.push_back(i == 0 ? s : s ^ 18'h20000);
            coding <= 1'b0;
            sel0 <= i > 0;
            sel1 <= i > 0;
            clk_src <= i == 0;
            rtc <= i == 2;
            div <= seed[19:18];
            cs_n <= i == 0;
            rd_n <= i == 0;
            apb(1'b1, `SADC_APB_SAMPLE, {14'h0, s});
            convert();
            chk(pwr, 1'b1);
            wait_for(0, 1'b0, w);
            chk(w + 22 >= 150, 1'b1);
            chk(pwr, 1'b0);
            if (i == 0) begin
                chk(w + 22 <= 153, 1'b1);
                cs_n <= 1'b0;
                rd_n <= 1'b0;
                repeat (3) @(posedge pclk);
                chk(data_bus.data_oe_n, 32'h0);
                chk(data_bus.data, res_q[0]);
                cs_n <= 1'b1;
                repeat (3) @(posedge pclk);
                chk(data_bus.data_oe_n, 32'h3ffff);
            end else begin
                if (i == 2) wait_for(1, 1'b0, n);
                // both frames carry the second conversion: its own, then the previous
                expv = res_q[1];
                chk(w + 22 >= 150 + 36, i == 1);
                chk(ser.sclk_oe_n, 1'b0);
                chk(bits, 6'd18);
                chk(word, expv);
            end
        end
        // free run in 16-bit binary mode, then read the word on 16 and 8 bits
        sel0 <= 1'b1;
        sel1 <= 1'b0;
        coding <= 1'b1;
        refpd <= 1'b1;
        cnv_n <= 1'b0;
        res_q.push_back(s);
        n = 0;
        bq = 1'b0;
        for (i = 0; i < 800; i++) begin
            @(posedge pclk);
            if (busy === 1'b1 && bq !== 1'b1) n++;
            bq = busy;
        end
        cnv_n <= 1'b1;
        chk(n >= 3, 1'b1);
        chk(ref_en, 1'b0);
        expv = res_q[3];
        chk(data_bus.data, {2'b00, expv[17:2]});
        sel0 <= 1'b0;
        sel1 <= 1'b1;
        rtc <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(data_bus.data, {10'h000, expv[17:10]});
        rtc <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(data_bus.data, {10'h000, expv[9:2]});
        // inverted polarity shows on the idle serial clock and data-valid lines
        apb(1'b1, `SADC_APB_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk(ser.sclk, 1'b1);
        chk(ser.sync, 1'b1);
        apb(1'b0, `SADC_APB_CTRL, 32'h0);
        chk(q, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
